// >>> tx_offload_dev_model.sv
`timescale 1ns/1ps
// ****************************************
// Device side of the bulk-out word stream
// ****************************************
module tx_offload_dev_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] data,
    input wire logic valid,
    input wire logic slow,
    input wire logic errInject,
    output logic ready,
    output logic errFlag
);
    logic [1:0] cnt;
    logic [1:0] idx;
    logic [17:0] left;
    logic lsoSeen;
    // Slow mode takes one word in four, so the host buffer fills up
    assign ready = !slow || cnt == 2'h0;
    // Walk command A, command B, then the data words of the frame
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            idx <= 2'h0;
            left <= 18'h00000;
            lsoSeen <= 1'b0;
            errFlag <= 1'b0;
        end else begin
            cnt <= cnt + 2'h1;
            if (errInject) begin
                errFlag <= 1'b1;
            end
            if (valid && ready && idx == 2'h0) begin
                lsoSeen <= data[tx_offload_pkg::LSO_BIT];
                left <= 18'((data[19:0] + 20'h00003) >> 2);
                idx <= 2'h1;
            end else if (valid && ready && idx == 2'h1) begin
                // Sync error is sticky: only a reset recovers the path
                if ((lsoSeen && data[29:16] < 14'h0008) ||
                    (!lsoSeen && data[29:16] != 14'h0000)) begin
                    errFlag <= 1'b1;
                end
                idx <= (left == 18'h00000) ? 2'h0 : 2'h2;
            end else if (valid && ready) begin
                left <= left - 18'h00001;
                idx <= (left == 18'h00001) ? 2'h0 : 2'h2;
            end
        end
    end
endmodule // tx_offload_dev_model

// >>> tx_offload_host.sv
`timescale 1ns/1ps
module tx_offload_host #(
    parameter int DATA_W = 32
) (
    input wire logic clk,
    input wire logic rst,
    input wire tx_offload_pkg::req_t req,
    input wire logic reqValid,
    output logic reqReady,
    output logic reqRejected,
    input wire logic [DATA_W-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [DATA_W-1:0] outData,
    output logic outValid,
    input wire logic outReady,
    input wire logic transmitErrorFlag,
    output logic txErrSticky,
    output logic busy
);

    // ****************************************
    // Request check and command words
    // ****************************************
    tx_offload_pkg::state_t state_ff, nxt_state;
    tx_offload_pkg::req_t req_ff, nxt_req;
    logic [17:0] words_ff, nxt_words;
    logic reqBad;
    logic reqTake;
    logic [DATA_W-1:0] cmdA;
    logic [DATA_W-1:0] cmdB;
    logic bufInValid;
    logic bufInReady;
    logic [DATA_W-1:0] bufInData;

    // Refuse anything the device would flag as a catastrophic TX error
    always_comb begin
        reqBad = 1'b0;
        if (req.large_send_segmentation) begin
            if (req.max_segment_size < tx_offload_pkg::MSS_MIN) reqBad = 1'b1;
            if (req.hdrLen > tx_offload_pkg::TMPL_MAX) reqBad = 1'b1;
            if (req.l4Udp || req.l4Other) reqBad = 1'b1;
            if (req.tun4in4 || req.tun6in4) reqBad = 1'b1;
            if (req.ipFrag || req.stackedVlan) reqBad = 1'b1;
            if (req.tmplFragBad || req.tmplLenNz) reqBad = 1'b1;
            if (!req.tmplIdOk) reqBad = 1'b1;
            if (!req.tmplSeqFirst) reqBad = 1'b1;
            if (req.tmplFlagsBad) reqBad = 1'b1;
        end else begin
            if (req.max_segment_size != 14'h0000) reqBad = 1'b1;
            if (req.frameLen[19:16] != 4'h0) reqBad = 1'b1;
            if (req.frameLen[15:0] > tx_offload_pkg::PLAIN_LEN_MAX) begin
                reqBad = 1'b1;
            end
        end
    end

    assign reqReady = (state_ff == tx_offload_pkg::ST_IDLE);
    assign reqTake = reqValid && reqReady && !reqBad;
    assign reqRejected = reqValid && reqReady && reqBad;
    assign busy = (state_ff != tx_offload_pkg::ST_IDLE);

    // Enables follow the request only; unsupported kinds are masked
    // so a stray request cannot produce a bogus checksum
    always_comb begin
        cmdA = '0;
        cmdA[tx_offload_pkg::LEN_LSB +: tx_offload_pkg::LEN_W] =
            req_ff.frameLen;
        cmdA[tx_offload_pkg::FCS_BIT] = req_ff.fcs;
        cmdA[tx_offload_pkg::IPCSUM_BIT] = req_ff.ipCsum
            && !req_ff.ipv6 && !req_ff.tun4in4;
        cmdA[tx_offload_pkg::TCSUM_BIT] = req_ff.l4Csum
            && !req_ff.tun4in4 && !req_ff.l4Other;
        cmdA[tx_offload_pkg::ICMP_BIT] = req_ff.icmpCsum
            && !req_ff.tun4in4;
        cmdA[tx_offload_pkg::IGMP_BIT] = req_ff.igmpCsum && !req_ff.ipv6
            && !req_ff.tun4in4 && !req_ff.tun6in4;
        cmdA[tx_offload_pkg::LSO_BIT] = req_ff.large_send_segmentation;
        cmdB = '0;
        cmdB[tx_offload_pkg::MSS_LSB +: tx_offload_pkg::MSS_W] =
            req_ff.max_segment_size;
    end

    // ****************************************
    // Frame sequencer
    // ****************************************
    // Command A, command B, then the template and payload words
    always_comb begin
        nxt_state = state_ff;
        nxt_req = req_ff;
        nxt_words = words_ff;
        bufInValid = 1'b0;
        bufInData = inData;
        inReady = 1'b0;
        case (state_ff)
            tx_offload_pkg::ST_IDLE: begin
                if (reqTake) begin
                    nxt_req = req;
                    nxt_words = 18'((22'(req.frameLen) + 22'h3) >> 2);
                    nxt_state = tx_offload_pkg::ST_CMDA;
                end
            end
            tx_offload_pkg::ST_CMDA: begin
                bufInValid = 1'b1;
                bufInData = cmdA;
                if (bufInReady) nxt_state = tx_offload_pkg::ST_CMDB;
            end
            tx_offload_pkg::ST_CMDB: begin
                bufInValid = 1'b1;
                bufInData = cmdB;
                if (bufInReady) begin
                    nxt_state = (words_ff == tx_offload_pkg::WORDS_RST) ?
                        tx_offload_pkg::ST_IDLE : tx_offload_pkg::ST_DATA;
                end
            end
            tx_offload_pkg::ST_DATA: begin
                bufInValid = inValid;
                inReady = bufInReady;
                if (inValid && bufInReady) begin
                    nxt_words = words_ff - 18'h00001;
                    if (words_ff == 18'h00001) begin
                        nxt_state = tx_offload_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                nxt_state = tx_offload_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= tx_offload_pkg::ST_IDLE;
            req_ff <= '0;
            words_ff <= tx_offload_pkg::WORDS_RST;
        end else begin
            state_ff <= nxt_state;
            req_ff <= nxt_req;
            words_ff <= nxt_words;
        end
    end

    // ****************************************
    // Two-entry output buffer
    // ****************************************
    logic [DATA_W-1:0] mem_ff [2];
    logic [DATA_W-1:0] nxt_mem [2];
    logic [1:0] cnt_ff, nxt_cnt;
    logic wp_ff, nxt_wp;
    logic rp_ff, nxt_rp;
    logic push;
    logic pop;

    // Two slots let the device stall for a cycle without a bubble
    assign bufInReady = (cnt_ff != 2'h2);
    assign outValid = (cnt_ff != 2'h0);
    assign outData = mem_ff[rp_ff];
    assign push = bufInValid && bufInReady;
    assign pop = outValid && outReady;

    always_comb begin
        nxt_mem = mem_ff;
        nxt_wp = wp_ff;
        nxt_rp = rp_ff;
        nxt_cnt = cnt_ff;
        if (push) begin
            nxt_mem[wp_ff] = bufInData;
            nxt_wp = !wp_ff;
        end
        if (pop) nxt_rp = !rp_ff;
        if (push && !pop) nxt_cnt = cnt_ff + 2'h1;
        if (pop && !push) nxt_cnt = cnt_ff - 2'h1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_ff[0] <= '0;
            mem_ff[1] <= '0;
            cnt_ff <= tx_offload_pkg::PTR_RST;
            wp_ff <= 1'b0;
            rp_ff <= 1'b0;
        end else begin
            mem_ff <= nxt_mem;
            cnt_ff <= nxt_cnt;
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
        end
    end

    // ****************************************
    // Device error flag
    // ****************************************
    logic errMeta_ff, errSync_ff, errSticky_ff;
    logic nxt_sticky;

    // Only reset clears it: the device needs a reset to recover anyway
    always_comb begin
        nxt_sticky = errSticky_ff || errSync_ff;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            errMeta_ff <= 1'b0;
            errSync_ff <= 1'b0;
            errSticky_ff <= 1'b0;
        end else begin
            errMeta_ff <= transmitErrorFlag;
            errSync_ff <= errMeta_ff;
            errSticky_ff <= nxt_sticky;
        end
    end

    assign txErrSticky = errSticky_ff;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_take;
        reqValid && reqReady && !reqBad;
    endsequence

    sequence s_cmdA_out;
        state_ff == tx_offload_pkg::ST_CMDA && bufInReady;
    endsequence

    a_lso_bit_follows: assert property (
        s_take |=> (cmdA[tx_offload_pkg::LSO_BIT] == $past(req.large_send_segmentation)))
        else $error("Segmentation bit differs from request");
    a_ip_enable_gated: assert property (
        s_cmdA_out ##0 cmdA[tx_offload_pkg::IPCSUM_BIT] |->
        req_ff.ipCsum && !req_ff.ipv6 && !req_ff.tun4in4)
        else $error("IP checksum bit without request");
    a_icmp_igmp_gated: assert property (
        s_cmdA_out |-> (!cmdA[tx_offload_pkg::ICMP_BIT] || req_ff.icmpCsum)
        && (!cmdA[tx_offload_pkg::IGMP_BIT] || req_ff.igmpCsum))
        else $error("ICMP or IGMP bit without request");
    a_mss_word_b: assert property (
        s_cmdA_out |=> state_ff == tx_offload_pkg::ST_CMDB
        && bufInData[29:16] == req_ff.max_segment_size
        && (!req_ff.large_send_segmentation || req_ff.max_segment_size >= 14'h0008))
        else $error("Command B segment size wrong");
    a_tmpl_limit: assert property (
        s_take ##0 req.large_send_segmentation |-> req.hdrLen <= 10'h100)
        else $error("Oversized template accepted");
    a_no_udp_lso: assert property (
        s_take ##0 req.large_send_segmentation |-> !req.l4Udp)
        else $error("UDP segmentation accepted");
    a_no_tunnel_lso: assert property (
        s_take ##0 req.large_send_segmentation |-> !req.tun4in4 && !req.tun6in4)
        else $error("Tunnelled segmentation accepted");
    a_tmpl_clean: assert property (
        s_take ##0 req.large_send_segmentation |-> !req.tmplFragBad && !req.tmplLenNz)
        else $error("Template fragment fields not clean");
    a_tmpl_seq_flags: assert property (
        s_take ##0 req.large_send_segmentation |-> req.tmplSeqFirst && !req.tmplFlagsBad)
        else $error("Template sequence or flags bad");
    a_reject_stays: assert property (
        reqRejected |=> state_ff == tx_offload_pkg::ST_IDLE)
        else $error("Rejected request started a frame");
    // A stalled word must not move, or the device loses template bytes
    a_out_hold: assert property (
        outValid && !outReady |=> outValid && $stable(outData))
        else $error("Output word changed while stalled");

endmodule // tx_offload_host

// >>> tx_offload_host_tb.sv
`timescale 1ns/1ps
module tx_offload_host_tb;
    logic clk, rst, reqValid, reqReady, reqRejected, inValid, inReady;
    logic outValid, outReady, errFlag, txErrSticky, busy, slow, errInject;
    logic [31:0] inData, outData;
    tx_offload_pkg::req_t req, base, good;
    logic [31:0] exp[$];
    int failures = 0, checked = 0, seed = 32'hf72e, i;

    tx_offload_host DUT (.clk(clk), .rst(rst), .req(req),
        .reqValid(reqValid), .reqReady(reqReady), .reqRejected(reqRejected),
        .inData(inData), .inValid(inValid), .inReady(inReady),
        .outData(outData), .outValid(outValid), .outReady(outReady),
        .transmitErrorFlag(errFlag), .txErrSticky(txErrSticky), .busy(busy));
    tx_offload_dev_model dev (.clk(clk), .rst(rst), .data(outData),
        .valid(outValid), .slow(slow), .errInject(errInject),
        .ready(outReady), .errFlag(errFlag));

    // ****************************************
    // Clock, compare tasks and expectations
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task check_word(input string n, input logic [31:0] e,
        input logic [31:0] s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask

    task check_bit(input string n, input logic e, input logic s);
        checked++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %b seen %b", n, e, s);
        end
    endtask

    task test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Enables the device is allowed to see for this packet kind
    function automatic logic [31:0] cmd_a(input tx_offload_pkg::req_t r);
        logic [31:0] w;
        w = {12'h000, r.frameLen};
        w[tx_offload_pkg::FCS_BIT] = r.fcs;
        w[tx_offload_pkg::IPCSUM_BIT] = r.ipCsum & !r.ipv6 & !r.tun4in4;
        w[tx_offload_pkg::TCSUM_BIT] = r.l4Csum & !r.l4Other
            & !r.tun4in4;
        w[tx_offload_pkg::LSO_BIT] = r.large_send_segmentation;
        w[tx_offload_pkg::ICMP_BIT] = r.icmpCsum & !r.tun4in4;
        w[tx_offload_pkg::IGMP_BIT] = r.igmpCsum & !r.ipv6 & !r.tun4in4
            & !r.tun6in4;
        return w;
    endfunction

    // Each word leaving the host must match the oldest note
    always @(posedge clk) begin
        if (outValid === 1'b1 && outReady === 1'b1) begin
            if (exp.size() == 0) begin
                failures++;
                $display("Error outData expected none seen %h", outData);
            end else begin
                check_word("outData", exp.pop_front(), outData);
            end
        end
    end

    // ****************************************
    // Drivers and scenarios
    // ****************************************
    task wait_in;
        int t;
        t = 0;
        @(negedge clk);
        while (inReady !== 1'b1 && t < 1000) begin
            @(negedge clk);
            t++;
        end
        check_bit("inReady", 1'b1, inReady);
        @(posedge clk);
    endtask

    task send(input tx_offload_pkg::req_t r, input logic s);
        int k, t;
        logic [31:0] w;
        exp.push_back(cmd_a(r));
        exp.push_back(r.large_send_segmentation ? {2'h0, r.max_segment_size, 16'h0000} : 32'h0);
        @(posedge clk);
        req <= r;
        reqValid <= 1'b1;
        slow <= s;
        @(posedge clk);
        reqValid <= 1'b0;
        for (k = 0; k < (r.frameLen + 3) / 4; k++) begin
            w = $random(seed);
            exp.push_back(w);
            inData <= w;
            inValid <= 1'b1;
            wait_in;
        end
        inValid <= 1'b0;
        t = 0;
        while ((exp.size() != 0 || busy !== 1'b0) && t < 5000) begin
            @(negedge clk);
            t++;
        end
        check_bit("drained", 1'b1, t < 5000);
    endtask

    // A bad request is refused at once and never starts a frame
    task refuse(input int k);
        tx_offload_pkg::req_t r;
        r = good;
        case (k)
            0: r.max_segment_size = 14'h0007;
            1: r.hdrLen = 10'h101;
            2: r.l4Udp = 1'b1;
            3: r.tun4in4 = 1'b1;
            4: r.tun6in4 = 1'b1;
            5: r.ipFrag = 1'b1;
            6: r.tmplLenNz = 1'b1;
            7: r.tmplIdOk = 1'b0;
            8: r.tmplFlagsBad = 1'b1;
            9: {r.large_send_segmentation, r.max_segment_size} = {1'b0, 14'h0001};
            10: {r.large_send_segmentation, r.max_segment_size, r.frameLen} = {1'b0, 14'h0000, 20'h02FF8};
            11: {r.large_send_segmentation, r.max_segment_size, r.frameLen} = {1'b0, 14'h0000, 20'h10000};
            12: r.l4Other = 1'b1;
            13: r.stackedVlan = 1'b1;
            14: r.tmplFragBad = 1'b1;
            default: r.tmplSeqFirst = 1'b0;
        endcase
        @(posedge clk);
        req <= r;
        reqValid <= 1'b1;
        @(negedge clk);
        check_bit("reqRejected", 1'b1, reqRejected);
        @(posedge clk);
        reqValid <= 1'b0;
        @(negedge clk);
        check_bit("busy", 1'b0, busy);
    endtask

    initial begin
        rst = 1'b1;
        reqValid = 1'b0;
        inValid = 1'b0;
        inData = 32'h0;
        req = '0;
        slow = 1'b0;
        errInject = 1'b0;
        repeat (11) @(posedge clk);
        @(negedge clk);
        check_bit("reqReady", 1'b1, reqReady);
        check_bit("outValid", 1'b0, outValid);
        @(posedge clk);
        rst <= 1'b0;
        // Every packet kind, enables all on, then random
        for (i = 0; i < 10; i++) begin
            base = '0;
            {base.ipCsum, base.l4Csum, base.icmpCsum, base.igmpCsum,
                base.fcs} = i < 5 ? 5'h1F : 5'($random(seed));
            {base.ipv6, base.tun4in4, base.tun6in4, base.l4Other} =
                4'(5'h10 >> (i % 5));
            base.frameLen = 20'(i * 3);
            send(base, i[0]);
        end
        // Segmentation at the smallest size and the largest template
        good = '0;
        {good.large_send_segmentation, good.ipCsum, good.l4Csum} = 3'h7;
        {good.tmplIdOk, good.tmplSeqFirst} = 2'h3;
        good.max_segment_size = tx_offload_pkg::MSS_MIN;
        good.hdrLen = tx_offload_pkg::TMPL_MAX;
        good.frameLen = 20'h00104;
        send(good, 1'b1);
        for (i = 0; i < 16; i++) begin
            refuse(i);
        end
        base = '0;
        base.frameLen = 20'(tx_offload_pkg::PLAIN_LEN_MAX);
        send(base, 1'b0);
        // Device error turns sticky on the third edge after it rises
        @(posedge clk);
        errInject <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        check_bit("txErrSticky", 1'b0, txErrSticky);
        @(negedge clk);
        check_bit("txErrSticky", 1'b1, txErrSticky);
        // Only a reset clears the flag; the path must work again after it
        @(posedge clk);
        errInject <= 1'b0;
        rst <= 1'b1;
        @(negedge clk);
        check_bit("txErrSticky", 1'b0, txErrSticky);
        check_bit("reqReady", 1'b1, reqReady);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        base = '0;
        base.frameLen = 20'h00021;
        send(base, 1'b1);
        check_bit("txErrSticky", 1'b0, txErrSticky);
        test_done;
    end

    // Watchdog well past the longest expected run
    initial begin
        #300000;
        failures++;
        $display("Error watchdog expected finish seen hang");
        test_done;
    end
endmodule // tx_offload_host_tb

// >>> tx_offload_pkg.sv
// Behaviour
// - IP and L4 checksum only when enabled
// - ICMP and IGMP each own enable bit
// - Segmentation only when enable bit set
// - Template header at most 256 bytes
// - Never segment UDP packets
// - Never segment tunnelled IP packets
// - Template: no fragmenting, zero length, sane ID
// - Sequence at first byte, final FIN/PSH
// - Template: URG/RST/SYN clear, urgent pointer zero
// - Segment size counts payload bytes only
// - Segment size bits 29:16, at least 8
package tx_offload_pkg;

    // ****************************************
    // Command word layout
    // ****************************************
    localparam int LEN_LSB = 0;
    localparam int LEN_W = 20;
    localparam int FCS_BIT = 22;
    localparam int TCSUM_BIT = 25;
    localparam int IPCSUM_BIT = 26;
    localparam int LSO_BIT = 27;
    localparam int ICMP_BIT = 28;
    localparam int IGMP_BIT = 29;
    localparam int MSS_LSB = 16;
    localparam int MSS_W = 14;

    // ****************************************
    // Limits and reset values
    // ****************************************
    localparam logic [13:0] MSS_MIN = 14'h0008;
    localparam logic [9:0] TMPL_MAX = 10'h100;
    localparam logic [15:0] PLAIN_LEN_MAX = 16'h2FF7;
    localparam logic [17:0] WORDS_RST = 18'h00000;
    localparam logic [1:0] PTR_RST = 2'h0;

    // Request from the user side, one per frame
    typedef struct packed {
        logic [19:0] frameLen;
        logic [13:0] max_segment_size;
        logic [9:0] hdrLen;
        logic ipCsum;
        logic l4Csum;
        logic icmpCsum;
        logic igmpCsum;
        logic large_send_segmentation;
        logic fcs;
        logic ipv6;
        logic tun4in4;
        logic tun6in4;
        logic l4Udp;
        logic l4Other;
        logic ipFrag;
        logic stackedVlan;
        logic tmplFragBad;
        logic tmplLenNz;
        logic tmplIdOk;
        logic tmplSeqFirst;
        logic tmplFlagsBad;
    } req_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CMDA = 2'b01,
        ST_CMDB = 2'b10,
        ST_DATA = 2'b11
    } state_t;

endpackage
